// ### logic/cise_params.svh
`ifndef CISE_PARAMS_SVH
`define CISE_PARAMS_SVH
// ==========================================
// Register map (byte addresses)
`define CISE_ADDR_CTRL      12'h000
`define CISE_ADDR_INSTR     12'h004
`define CISE_ADDR_ACC       12'h008
`define CISE_ADDR_STATUS    12'h00C
`define CISE_ADDR_UPLATCH   12'h010
`define CISE_ADDR_PC        12'h014
`define CISE_ADDR_STACK     12'h018
`define CISE_ADDR_WDT       12'h01C
`define CISE_ADDR_FILE_BASE 12'h200
// ==========================================
// Status bits
`define CISE_ST_Z           0
`define CISE_ST_PD          3
`define CISE_ST_TO          4
// ==========================================
// Reset values and constants
`define CISE_ZERO8          8'h00
`define CISE_UNMAPPED       32'h0000_0000
`define CISE_RESP_OKAY      2'b00
`define CISE_RESP_SLVERR    2'b10
`define CISE_WDT_TICK_CYC   16'h0100
`endif

// ### logic/cise_pkg.sv
package cise_pkg;
    // ==========================================
    // Decoded operation codes
    typedef enum logic [2:0] {
        CISE_OP_NONE   = 3'b000,
        CISE_OP_CALL   = 3'b001,
        CISE_OP_WDCLR  = 3'b010,
        CISE_OP_FCLR   = 3'b011,
        CISE_OP_FINV   = 3'b100,
        CISE_OP_ACLR   = 3'b101,
        CISE_OP_FDEC   = 3'b110
    } cise_op_t;

    // ==========================================
    // Execution states
    typedef enum logic [1:0] {
        CISE_ST_IDLE   = 2'b00,
        CISE_ST_EXEC   = 2'b01,
        CISE_ST_CALL2  = 2'b10
    } cise_state_t;

    function automatic cise_op_t cise_decode(input logic [13:0] instr);
        cise_op_t op;
        op = CISE_OP_NONE;
        if (instr[13:11] == 3'b100) begin
            op = CISE_OP_CALL;
        end else if (instr == 14'h0064) begin
            op = CISE_OP_WDCLR;
        end else if (instr[13:7] == 7'h03) begin
            op = CISE_OP_FCLR;
        end else if (instr[13:7] == 7'h02) begin
            op = CISE_OP_ACLR;
        end else if (instr[13:8] == 6'h09) begin
            op = CISE_OP_FINV;
        end else if (instr[13:8] == 6'h03) begin
            op = CISE_OP_FDEC;
        end
        return op;
    endfunction : cise_decode
endpackage : cise_pkg

// ### logic/cise_watchdog.sv
`timescale 1ns/1ps
`include "cise_params.svh"
module cise_watchdog
    import cise_pkg::*;
#(
    parameter int TICK_CYC = 256
) (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       arst_n_in,
    // Control
    input  wire logic       clear_in,
    // State
    output logic [7:0]      watchdog_counter_out,
    output logic [15:0]     prescaler_out
);
    // ==========================================
    // Prescaler and counter
    logic [15:0] pre_q, pre_d;
    logic [7:0]  cnt_q, cnt_d;

    always_comb begin
        pre_d = pre_q + 16'h0001;
        cnt_d = cnt_q;
        if (pre_q == 16'(TICK_CYC - 1)) begin
            pre_d = 16'h0000;
            cnt_d = cnt_q + 8'h01;
        end
        if (clear_in) begin
            pre_d = 16'h0000;
            cnt_d = `CISE_ZERO8;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pre_q <= 16'h0000;
            cnt_q <= 8'h00;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    assign watchdog_counter_out = cnt_q;
    assign prescaler_out        = pre_q;
endmodule : cise_watchdog

// ### logic/cise_core.sv
// Function
// - Call loads its eleven-bit immediate into program counter bits 10:0.
// - Call fills counter bits 12:11 from upper latch bits 4:3.
// - Call pushes counter plus one onto the return stack head first.
// - Call takes two instruction cycles and leaves status flags unchanged.
// - Watchdog clear zeroes the watchdog counter and its prescaler.
// - Watchdog clear sets both timeout and power-down flags.
// - File clear writes zero into register 0..127 and sets zero flag.
// - Invert produces the bitwise complement, affecting only the zero flag.
// - Destination bit 0 selects accumulator, 1 writes back to the file.
// - Accumulator clear loads zero and sets the zero flag.
// - Decrement subtracts one and delivers result to chosen destination.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "cise_params.svh"
module cise_core
    import cise_pkg::*;
#(
    parameter int FILE_DEPTH = 128,
    parameter int STACK_DEPTH = 8,
    parameter int WDT_TICK_CYC = 256
) (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        arst_n_in,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // Core state
    output logic             busy_out
);
    // ==========================================
    // State
    cise_state_t       st_q, st_d;
    logic [13:0]       instr_q, instr_d;
    logic [7:0]        acc_q, acc_d;
    logic              z_q, z_d;
    logic              to_q, to_d;
    logic              pd_q, pd_d;
    logic [7:0]        upl_q, upl_d;
    logic [12:0]       pc_q, pc_d;
    logic [12:0]       stk_q [STACK_DEPTH];
    logic [2:0]        sp_q, sp_d;
    logic [7:0]        file_q [FILE_DEPTH];
    logic              fwe;
    logic [6:0]        faddr;
    logic [7:0]        fwdata;
    logic              push;
    logic              wdclr;
    logic [7:0]        wdt_cnt;
    cise_op_t          op;
    logic [7:0]        res;

    // AXI state
    logic              aw_hold_q, aw_hold_d;
    logic [11:0]       awaddr_q, awaddr_d;
    logic              w_hold_q, w_hold_d;
    logic [31:0]       wdata_q, wdata_d;
    logic [3:0]        wstrb_q, wstrb_d;
    logic              bvalid_q, bvalid_d;
    logic [1:0]        bresp_q, bresp_d;
    logic              rvalid_q, rvalid_d;
    logic [31:0]       rdata_q, rdata_d;
    logic [1:0]        rresp_q, rresp_d;
    logic              wr_go;
    logic              start;

    cise_watchdog #(
        .TICK_CYC (WDT_TICK_CYC)
    ) u_wdt (
        .mclk_in              (mclk_in),
        .arst_n_in            (arst_n_in),
        .clear_in             (wdclr),
        .watchdog_counter_out (wdt_cnt),
        .prescaler_out        ()
    );

    // ==========================================
    // Bus write acceptance
    assign s_axi_awready_out = !aw_hold_q && !bvalid_q;
    assign s_axi_wready_out  = !w_hold_q && !bvalid_q;
    assign wr_go             = aw_hold_q && w_hold_q && !bvalid_q;

    always_comb begin
        aw_hold_d = aw_hold_q;
        awaddr_d  = awaddr_q;
        w_hold_d  = w_hold_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_hold_d = 1'b1;
            awaddr_d  = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_hold_d = 1'b1;
            wdata_d  = s_axi_wdata_in;
            wstrb_d  = s_axi_wstrb_in;
        end
        if (wr_go) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = `CISE_RESP_OKAY;
            if (awaddr_q[11:9] != 3'b001 && awaddr_q > `CISE_ADDR_WDT) begin
                bresp_d = `CISE_RESP_SLVERR;
            end
        end
        if (bvalid_q && s_axi_bready_in) begin
            bvalid_d = 1'b0;
        end
    end

    assign start = wr_go && awaddr_q == `CISE_ADDR_INSTR && wstrb_q[0] && st_q == CISE_ST_IDLE;
    assign busy_out = st_q != CISE_ST_IDLE;

    // ==========================================
    // Execute
    assign op = cise_decode(instr_q);

    always_comb begin
        st_d    = st_q;
        instr_d = instr_q;
        acc_d   = acc_q;
        z_d     = z_q;
        to_d    = to_q;
        pd_d    = pd_q;
        upl_d   = upl_q;
        pc_d    = pc_q;
        sp_d    = sp_q;
        fwe     = 1'b0;
        faddr   = instr_q[6:0];
        fwdata  = `CISE_ZERO8;
        push    = 1'b0;
        wdclr   = 1'b0;
        res     = `CISE_ZERO8;
        case (st_q)
            CISE_ST_IDLE: begin
                if (start) begin
                    instr_d = wdata_q[13:0];
                    st_d    = CISE_ST_EXEC;
                end else if (wr_go && wstrb_q[0]) begin
                    if (awaddr_q == `CISE_ADDR_ACC) begin
                        acc_d = wdata_q[7:0];
                    end else if (awaddr_q == `CISE_ADDR_STATUS) begin
                        z_d  = wdata_q[`CISE_ST_Z];
                        to_d = wdata_q[`CISE_ST_TO];
                        pd_d = wdata_q[`CISE_ST_PD];
                    end else if (awaddr_q == `CISE_ADDR_UPLATCH) begin
                        upl_d = wdata_q[7:0];
                    end else if (awaddr_q == `CISE_ADDR_PC) begin
                        pc_d = wdata_q[12:0];
                    end else if (awaddr_q[11:9] == 3'b001) begin
                        fwe    = 1'b1;
                        faddr  = awaddr_q[8:2];
                        fwdata = wdata_q[7:0];
                    end
                end
            end
            CISE_ST_EXEC: begin
                st_d = CISE_ST_IDLE;
                pc_d = pc_q + 13'h0001;
                case (op)
                    CISE_OP_CALL: begin
                        push = 1'b1;
                        sp_d = sp_q + 3'h1;
                        pc_d = {upl_q[4:3], instr_q[10:0]};
                        st_d = CISE_ST_CALL2;
                    end
                    CISE_OP_WDCLR: begin
                        wdclr = 1'b1;
                        to_d  = 1'b1;
                        pd_d  = 1'b1;
                    end
                    CISE_OP_FCLR: begin
                        fwe    = 1'b1;
                        fwdata = `CISE_ZERO8;
                        z_d    = 1'b1;
                    end
                    CISE_OP_ACLR: begin
                        acc_d = `CISE_ZERO8;
                        z_d   = 1'b1;
                    end
                    CISE_OP_FINV, CISE_OP_FDEC: begin
                        if (op == CISE_OP_FINV) begin
                            res = ~file_q[faddr];
                        end else begin
                            res = file_q[faddr] - 8'h01;
                        end
                        z_d = (res == `CISE_ZERO8);
                        if (instr_q[7]) begin
                            fwe    = 1'b1;
                            fwdata = res;
                        end else begin
                            acc_d = res;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            CISE_ST_CALL2: begin
                st_d = CISE_ST_IDLE;
            end
            default: begin
                st_d = CISE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q      <= CISE_ST_IDLE;
            instr_q   <= 14'h0000;
            acc_q     <= 8'h00;
            z_q       <= 1'b0;
            to_q      <= 1'b1;
            pd_q      <= 1'b1;
            upl_q     <= 8'h00;
            pc_q      <= 13'h0000;
            sp_q      <= 3'h0;
            aw_hold_q <= 1'b0;
            awaddr_q  <= 12'h000;
            w_hold_q  <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'b00;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= 2'b00;
        end else begin
            st_q      <= st_d;
            instr_q   <= instr_d;
            acc_q     <= acc_d;
            z_q       <= z_d;
            to_q      <= to_d;
            pd_q      <= pd_d;
            upl_q     <= upl_d;
            pc_q      <= pc_d;
            sp_q      <= sp_d;
            aw_hold_q <= aw_hold_d;
            awaddr_q  <= awaddr_d;
            w_hold_q  <= w_hold_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // ==========================================
    // Memories
    always_ff @(posedge mclk_in) begin
        if (fwe) begin
            file_q[faddr] <= fwdata;
        end
        if (push) begin
            stk_q[sp_q] <= pc_q + 13'h0001;
        end
    end

    // ==========================================
    // Bus read
    assign s_axi_arready_out = !rvalid_q;

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && s_axi_rready_in) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_d = 1'b1;
            rresp_d  = `CISE_RESP_OKAY;
            rdata_d  = `CISE_UNMAPPED;
            case (s_axi_araddr_in)
                `CISE_ADDR_CTRL:    rdata_d = {31'h0, busy_out};
                `CISE_ADDR_INSTR:   rdata_d = {18'h0, instr_q};
                `CISE_ADDR_ACC:     rdata_d = {24'h0, acc_q};
                `CISE_ADDR_STATUS:  rdata_d = {27'h0, to_q, pd_q, 2'b00, z_q};
                `CISE_ADDR_UPLATCH: rdata_d = {24'h0, upl_q};
                `CISE_ADDR_PC:      rdata_d = {19'h0, pc_q};
                `CISE_ADDR_STACK:   rdata_d = {16'h0, sp_q, stk_q[sp_q - 3'h1]};
                `CISE_ADDR_WDT:     rdata_d = {24'h0, wdt_cnt};
                default: begin
                    if (s_axi_araddr_in[11:9] == 3'b001) begin
                        rdata_d = {24'h0, file_q[s_axi_araddr_in[8:2]]};
                    end else begin
                        rresp_d = `CISE_RESP_SLVERR;
                    end
                end
            endcase
        end
    end

    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out  = bresp_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out  = rdata_q;
    assign s_axi_rresp_out  = rresp_q;
endmodule : cise_core

// ### bench/cise_fetch_model.sv
`timescale 1ns/1ps
module cise_fetch_model (
    // Clock
    input  wire logic        mclk_in,
    // Write side
    output logic [11:0]      awaddr_out,
    output logic             awvalid_out,
    input  wire logic        awready_in,
    output logic [31:0]      wdata_out,
    output logic             wvalid_out,
    input  wire logic        wready_in,
    input  wire logic [1:0]  bresp_in,
    input  wire logic        bvalid_in,
    output logic             bready_out,
    // Read side
    output logic [11:0]      araddr_out,
    output logic             arvalid_out,
    input  wire logic        arready_in,
    input  wire logic [31:0] rdata_in,
    input  wire logic [1:0]  rresp_in,
    input  wire logic        rvalid_in,
    output logic             rready_out
);
    // ==========================================
    // Idle levels
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
        {araddr_out, arvalid_out, rready_out} = '0;
    end

    // ==========================================
    // Bus cycles; released lines show inverted data
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge mclk_in);
        awaddr_out <= a;
        wdata_out <= d;
        awvalid_out <= 1'b1;
        wvalid_out <= 1'b1;
        bready_out <= 1'b1;
        while (!tb) begin
            @(negedge mclk_in);
            ta = awvalid_out && awready_in;
            tw = wvalid_out && wready_in;
            tb = bvalid_in;
            r = bresp_in;
            @(posedge mclk_in);
            if (ta) begin
                awvalid_out <= 1'b0;
                awaddr_out <= ~a;
            end
            if (tw) begin
                wvalid_out <= 1'b0;
                wdata_out <= ~d;
            end
            if (tb) bready_out <= 1'b0;
        end
    endtask : wr

    // Read cycle; released address line shows inverted address
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        tr = 1'b0;
        @(posedge mclk_in);
        araddr_out <= a;
        arvalid_out <= 1'b1;
        rready_out <= 1'b1;
        while (!tr) begin
            @(negedge mclk_in);
            ta = arvalid_out && arready_in;
            tr = rvalid_in;
            d = rdata_in;
            r = rresp_in;
            @(posedge mclk_in);
            if (ta) begin
                arvalid_out <= 1'b0;
                araddr_out <= ~a;
            end
            if (tr) rready_out <= 1'b0;
        end
    endtask : rd
endmodule : cise_fetch_model

// ### bench/cise_core_checker.sv
`timescale 1ns/1ps
module cise_core_checker (
    // Clock and reset
    input wire logic        mclk_in,
    input wire logic        arst_n_in,
    // Bus
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0]  s_axi_wstrb_in,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0]  s_axi_rresp_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    // Core
    input wire logic        busy_out
);
    default clocking dcb @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);

    // ==========================================
    // Instruction start
    logic wr_hs;
    logic ar_hs;
    logic go;
    assign wr_hs = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;
    assign go = wr_hs && s_axi_awaddr_in == 12'h004 && !busy_out;

    chk_call_two: assert property (go && s_axi_wdata_in[13:11] == 3'b100 |->
        ##[1:3] $rose(busy_out) ##1 busy_out ##1 !busy_out) else $error("call length wrong");
    chk_op_one: assert property (go && s_axi_wdata_in[13:11] != 3'b100 |->
        ##[1:3] $rose(busy_out) ##1 !busy_out) else $error("single op length wrong");
    chk_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("bvalid dropped");
    chk_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("rvalid dropped");
    chk_r_answer: assert property (ar_hs |=> s_axi_rvalid_out) else $error("read answer late");
    chk_rd_unmapped: assert property (ar_hs && s_axi_araddr_in == 12'h020 |=>
        s_axi_rresp_out == 2'b10 && s_axi_rdata_out == 32'h0000_0000) else $error("bad rd err");
    chk_b_answer: assert property (wr_hs |-> ##[1:2] s_axi_bvalid_out) else $error("no bvalid");
    chk_aw_refused: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write taken while answer pending");

    cover property (go && s_axi_wdata_in[13:11] == 3'b100);
    cover property (go);
    cover property (s_axi_rvalid_out && s_axi_rresp_out == 2'b10);
endmodule : cise_core_checker

bind cise_core cise_core_checker chk_i (.mclk_in, .arst_n_in, .s_axi_awaddr_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
    .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .busy_out);

// ### bench/tb_top.sv
`timescale 1ns/1ps
`include "cise_params.svh"
module tb_top;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, busy;
    int failures, check_count, seed, f, v, op, dd, res, acc, zf, tof, pdf, l, p, k;
    int fm [128];

    always #25 mclk = ~mclk;

    cise_core #(.WDT_TICK_CYC(64)) uut (.mclk_in(mclk), .arst_n_in(arst_n),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .busy_out(busy));
    cise_fetch_model fetch (.mclk_in(mclk), .awaddr_out(awaddr), .awvalid_out(awvalid),
        .awready_in(awready), .wdata_out(wdata), .wvalid_out(wvalid), .wready_in(wready),
        .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr),
        .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata), .rresp_in(rresp),
        .rvalid_in(rvalid), .rready_out(rready));

    // ==========================================
    // Compare and bus helpers
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_resp

    task automatic put(input logic [11:0] a, input int val);
        fetch.wr(a, 32'(val), r);
        cmp_resp(r, 2'b00);
    endtask : put

    task automatic rd_chk(input logic [11:0] a, input int exp, input int m);
        fetch.rd(a, d, r);
        cmp_resp(r, 2'b00);
        cmp_val(d & 32'(m), 32'(exp));
    endtask : rd_chk

    task automatic exec(input logic [13:0] ins);
        put(`CISE_ADDR_INSTR, {18'h0, ins});
        @(negedge mclk);
        while (busy) @(negedge mclk);
    endtask : exec

    function automatic int sts();
        return (tof << 4) | (pdf << 3) | zf;
    endfunction : sts

    task automatic final_report();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (40000) @(posedge mclk);
        failures++;
        final_report();
    end

    // ==========================================
    // Main sequence
    initial begin
        seed = 780;
        failures = 0;
        check_count = 0;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        {tof, pdf, zf, acc} = {32'd1, 32'd1, 32'd0, 32'd0};
        rd_chk(`CISE_ADDR_STATUS, sts(), 'h19);
        put(`CISE_ADDR_STATUS, 0);
        {tof, pdf} = {32'd0, 32'd0};
        repeat (300) @(posedge mclk);
        exec(14'h0064);
        {tof, pdf} = {32'd1, 32'd1};
        rd_chk(`CISE_ADDR_WDT, 0, 'hFF);
        rd_chk(`CISE_ADDR_STATUS, sts(), 'h19);
        repeat (50) @(posedge mclk);
        rd_chk(`CISE_ADDR_WDT, 0, 'hFF);
        repeat (10) @(posedge mclk);
        rd_chk(`CISE_ADDR_WDT, 1, 'hFF);
        for (int i = 0; i < 24; i++) begin
            f = (i == 0) ? 127 : ($random(seed) & 127);
            v = (i % 4 == 1) ? 1 : (i % 4 == 2) ? 255 : ($random(seed) & 255);
            op = i % 3;
            dd = $random(seed) & 1;
            put(`CISE_ADDR_FILE_BASE + 12'(f * 4), v);
            fm[f] = v;
            res = (op == 0) ? 0 : (op == 1) ? (~v & 255) : ((v - 1) & 255);
            zf = (res == 0);
            exec((op == 0) ? {7'h03, 7'(f)} : {(op == 1) ? 6'h09 : 6'h03, 1'(dd), 7'(f)});
            if (op == 0 || dd == 1) fm[f] = res;
            else acc = res;
            rd_chk(`CISE_ADDR_FILE_BASE + 12'(f * 4), fm[f], 'hFF);
            rd_chk(`CISE_ADDR_ACC, acc, 'hFF);
            rd_chk(`CISE_ADDR_STATUS, sts(), 'h19);
        end
        put(`CISE_ADDR_ACC, ($random(seed) & 255) | 1);
        exec(14'h0100);
        {acc, zf} = {32'd0, 32'd1};
        rd_chk(`CISE_ADDR_ACC, acc, 'hFF);
        rd_chk(`CISE_ADDR_STATUS, sts(), 'h19);
        for (int i = 0; i < 4; i++) begin
            l = (i == 0) ? 'h18 : ($random(seed) & 31);
            k = (i == 0) ? 2047 : ($random(seed) & 'h7FF);
            p = $random(seed) & 'h1FFF;
            {tof, pdf, zf} = {$random(seed) & 1, $random(seed) & 1, $random(seed) & 1};
            put(`CISE_ADDR_UPLATCH, l);
            put(`CISE_ADDR_PC, p);
            put(`CISE_ADDR_STATUS, sts());
            exec({3'b100, 11'(k)});
            rd_chk(`CISE_ADDR_PC, (((l >> 3) & 3) << 11) | k, 'h1FFF);
            rd_chk(`CISE_ADDR_STACK, ((i + 1) << 13) | ((p + 1) & 'h1FFF), 'hFFFF);
            rd_chk(`CISE_ADDR_STATUS, sts(), 'h19);
        end
        fetch.rd(12'h020, d, r);
        cmp_resp(r, 2'b10);
        cmp_val(d, 32'h0000_0000);
        fetch.wr(12'h020, 32'h0000_00A5, r);
        cmp_resp(r, 2'b10);
        final_report();
    end
endmodule : tb_top
